/* hdl/pta_top.sv */
// Protection frame: availability, blocking, alarm/trip aggregation, Avalon-MM registers
//
// Overview of operation
// - Available only when idle editing and measurements valid
// - Disabled or blocked protection stops all elements
// - Permitted external blocks on assigned inputs block all protection
// - Permanent trip block suppresses every trip command
// - Permitted, assigned trip-block input suppresses trip commands
// - Forward element results only if not supervision-only
// - Supervision-only elements keep local state, no command
// - Element alarms as soon as fault seen
// - Element trips if fault persists past delay
// - General alarm ORs forwarded alarms
// - General trip ORs forwarded trips
// - Trip command only when not blocked
// - Per-phase alarms OR forwarded phase alarms
// - Per-phase trips OR forwarded phase trips
// - Only single-phase capable, non-supervision elements feed phases
module pta_top
   import pta_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic                 rstn,
   input  wire logic [5:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output logic      [31:0]          avs_readdata,
   output logic                      avs_waitrequest,
   input  wire logic                 measValid,
   input  wire logic                 nonSetParamEdit,
   input  wire logic                 block_input_a,
   input  wire logic                 block_input_b,
   input  wire logic                 trip_block_input,
   input  wire logic [NUM_ELEM-1:0]  elemFault,
   input  wire logic [NUM_PHASE-1:0] elemFaultPhase [NUM_ELEM],
   output logic                      protAvailable,
   output logic                      protActive,
   output logic                      protection_blocked,
   output logic                      generalAlarm,
   output logic                      generalTrip,
   output logic [NUM_PHASE-1:0]      phase_one_alarm,
   output logic [NUM_PHASE-1:0]      phase_one_trip,
   output logic [NUM_ELEM-1:0]       trip_command,
   output logic [NUM_ELEM-1:0]       elemAlarmState,
   output logic [NUM_ELEM-1:0]       elemTripState
);
   logic [31:0]        cfg_reg;
   logic [31:0]        elemCfg_reg;
   logic [DELAY_W-1:0] delay_reg [NUM_ELEM];
   pta_bus_e           busState_reg;
   logic [2:0]         syncA_reg;
   logic [2:0]         syncB_reg;
   logic [2:0]         syncT_reg;
   logic [2:0]         syncM_reg;
   logic [2:0]         syncE_reg;
   logic               blkA_reg;
   logic               blkB_reg;
   logic               blkT_reg;
   logic               measOk_reg;
   logic               editing_reg;
   logic [NUM_ELEM-1:0] alarmRaw;
   logic [NUM_ELEM-1:0] tripRaw;
   logic [NUM_ELEM-1:0] fwdMask;
   logic [NUM_ELEM-1:0] phaseMask;
   logic [NUM_PHASE-1:0] phAlarmNext;
   logic [NUM_PHASE-1:0] phTripNext;
   logic               activeNext;
   logic               blockedNext;
   logic               tripBlockNext;
   logic [5:0]         addrLatch_reg;
   logic               wrTaken;

   // Word index decode of a byte offset, shared by read and write paths
   function automatic logic hit(input logic [5:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs[7:2]);
   endfunction

   // Word index of one element's delay register
   function automatic logic delayHit(input logic [5:0] addr, input int idx);
      delayHit = (addr == 6'(DELAY0_OFS[7:2] + idx));
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // Pin inputs: three stages, a change counts when stages two and three agree
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         syncA_reg <= '0;
         syncB_reg <= '0;
         syncT_reg <= '0;
         syncM_reg <= '0;
         syncE_reg <= '0;
      end else begin
         syncA_reg <= {syncA_reg[1:0], block_input_a};
         syncB_reg <= {syncB_reg[1:0], block_input_b};
         syncT_reg <= {syncT_reg[1:0], trip_block_input};
         syncM_reg <= {syncM_reg[1:0], measValid};
         syncE_reg <= {syncE_reg[1:0], nonSetParamEdit};
      end
   end

   // Pulses shorter than two cycles never reach the frame
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         blkA_reg    <= 1'b0;
         blkB_reg    <= 1'b0;
         blkT_reg    <= 1'b0;
         measOk_reg  <= 1'b0;
         editing_reg <= 1'b0;
      end else begin
         if (syncA_reg[1] == syncA_reg[2]) begin
            blkA_reg <= syncA_reg[2];
         end
         if (syncB_reg[1] == syncB_reg[2]) begin
            blkB_reg <= syncB_reg[2];
         end
         if (syncT_reg[1] == syncT_reg[2]) begin
            blkT_reg <= syncT_reg[2];
         end
         if (syncM_reg[1] == syncM_reg[2]) begin
            measOk_reg <= syncM_reg[2];
         end
         if (syncE_reg[1] == syncE_reg[2]) begin
            editing_reg <= syncE_reg[2];
         end
      end
   end

   // Frame decisions
   always_comb begin
      // Unassigned inputs are masked by their assign bits
      blockedNext = cfg_reg[CFG_EXBLK_BIT]
                    && ((cfg_reg[CFG_ASGA_BIT] && blkA_reg)
                        || (cfg_reg[CFG_ASGB_BIT] && blkB_reg));
      activeNext  = cfg_reg[CFG_ENABLE_BIT] && !blockedNext;
      tripBlockNext = cfg_reg[CFG_PERMTB_BIT]
                      || (cfg_reg[CFG_EXTTB_BIT] && cfg_reg[CFG_ASGT_BIT]
                          && blkT_reg);
      fwdMask   = ~elemCfg_reg[EC_SUPV_LSB +: NUM_ELEM];
      phaseMask = fwdMask & elemCfg_reg[EC_ONEP_LSB +: NUM_ELEM];
   end

   // Elements clear their timers while protection is off
   genvar g;
   generate
      for (g = 0; g < NUM_ELEM; g++) begin : gElem
         pta_element uElem (
            .ref_clk     (ref_clk),
            .rstn        (rstn),
            .enable      (activeNext),
            .fault       (elemFault[g]),
            .delayCycles (delay_reg[g]),
            .alarm       (alarmRaw[g]),
            .trip        (tripRaw[g])
         );
      end
   endgenerate

   // Phase ORs see only forwarded, single-phase capable elements
   always_comb begin
      phAlarmNext = '0;
      phTripNext  = '0;
      for (int e = 0; e < NUM_ELEM; e++) begin
         if (phaseMask[e]) begin
            phAlarmNext = phAlarmNext | (alarmRaw[e] ? elemFaultPhase[e] : '0);
            phTripNext  = phTripNext | (tripRaw[e] ? elemFaultPhase[e] : '0);
         end
      end
   end

   // Frame state: availability, active, blocked
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         protAvailable      <= 1'b0;
         protActive         <= 1'b0;
         protection_blocked <= 1'b0;
      end else begin
         protAvailable      <= !editing_reg && !cfg_reg[CFG_EDIT_BIT] && measOk_reg;
         protActive         <= activeNext;
         protection_blocked <= blockedNext;
      end
   end

   // General signals only see forwarded elements
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         generalAlarm <= 1'b0;
         generalTrip  <= 1'b0;
      end else begin
         generalAlarm <= |(alarmRaw & fwdMask);
         generalTrip  <= |(tripRaw & fwdMask);
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         phase_one_alarm <= '0;
         phase_one_trip  <= '0;
      end else begin
         phase_one_alarm <= phAlarmNext;
         phase_one_trip  <= phTripNext;
      end
   end

   // Blocked commands still leave alarms and trips visible
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         trip_command <= '0;
      end else begin
         trip_command <= tripBlockNext ? '0 : (tripRaw & fwdMask);
      end
   end

   // Local states kept for supervision-only elements too
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         elemAlarmState <= '0;
         elemTripState  <= '0;
      end else begin
         elemAlarmState <= alarmRaw;
         elemTripState  <= tripRaw;
      end
   end

   // Avalon slave: request taken in IDLE, answered one cycle later
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         busState_reg  <= PTA_IDLE;
         addrLatch_reg <= '0;
      end else begin
         case (busState_reg)
            PTA_IDLE: begin
               if (avs_read || avs_write) begin
                  busState_reg  <= PTA_RESP;
                  addrLatch_reg <= avs_address;
               end
            end
            PTA_RESP: begin
               busState_reg <= PTA_DONE;
            end
            PTA_DONE: begin
               busState_reg <= PTA_IDLE;
            end
            default: begin
               busState_reg <= PTA_IDLE;
            end
         endcase
      end
   end

   // Waitrequest low for exactly one cycle per request
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !(busState_reg == PTA_IDLE && (avs_read || avs_write));
      end
   end

   // Writes land at the edge where waitrequest is seen low
   assign wrTaken = busState_reg == PTA_RESP && avs_write;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_reg <= CFG_RST;
      end else if (wrTaken && hit(addrLatch_reg, CFG_OFS)) begin
         cfg_reg <= merge(cfg_reg, avs_writedata, avs_byteenable) & 32'h0000_00FF;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         elemCfg_reg <= ELEMCFG_RST;
      end else if (wrTaken && hit(addrLatch_reg, ELEMCFG_OFS)) begin
         elemCfg_reg <= merge(elemCfg_reg, avs_writedata, avs_byteenable)
                        & 32'h0000_0F0F;
      end
   end

   // Delay registers keep only the low half of the word
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_ELEM; i++) begin
            delay_reg[i] <= DELAY_RST;
         end
      end else if (wrTaken) begin
         for (int i = 0; i < NUM_ELEM; i++) begin
            if (delayHit(addrLatch_reg, i)) begin
               delay_reg[i] <= 16'(merge({16'h0000, delay_reg[i]}, avs_writedata,
                                         avs_byteenable));
            end
         end
      end
   end

   // Read data taken at the request edge, stands until the next read
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         avs_readdata <= '0;
      end else if (busState_reg == PTA_IDLE && avs_read) begin
         avs_readdata <= UNMAPPED_DATA;
         if (hit(avs_address, CFG_OFS)) begin
            avs_readdata <= cfg_reg;
         end
         if (hit(avs_address, ELEMCFG_OFS)) begin
            avs_readdata <= elemCfg_reg;
         end
         if (hit(avs_address, STATUS_OFS)) begin
            avs_readdata <= {17'h0_0000, phase_one_trip, phase_one_alarm, 3'h0,
                             tripBlockNext, generalTrip, generalAlarm,
                             protection_blocked, protActive, protAvailable};
         end
         if (hit(avs_address, ELEMSTAT_OFS)) begin
            avs_readdata <= {8'h00, 4'h0, trip_command, 4'h0, elemTripState,
                             4'h0, elemAlarmState};
         end
         if (hit(avs_address, IDENT_OFS)) begin
            avs_readdata <= IDENT_VALUE;
         end
         for (int i = 0; i < NUM_ELEM; i++) begin
            if (delayHit(avs_address, i)) begin
               avs_readdata <= {16'h0000, delay_reg[i]};
            end
         end
      end
   end
endmodule

/* hdl/pta_pkg.sv */
// Constants, register map and types of the protection trip aggregator
package pta_pkg;
   localparam int          NUM_ELEM        = 4;
   localparam int          NUM_PHASE       = 3;
   localparam int          DELAY_W         = 16;
   // Register byte offsets
   localparam logic [7:0]  CFG_OFS         = 8'h00;
   localparam logic [7:0]  ELEMCFG_OFS     = 8'h04;
   localparam logic [7:0]  STATUS_OFS      = 8'h08;
   localparam logic [7:0]  ELEMSTAT_OFS    = 8'h0C;
   localparam logic [7:0]  DELAY0_OFS      = 8'h10;
   localparam logic [7:0]  IDENT_OFS       = 8'h20;
   // Global control fields
   localparam int          CFG_ENABLE_BIT  = 0;
   localparam int          CFG_EXBLK_BIT   = 1;
   localparam int          CFG_PERMTB_BIT  = 2;
   localparam int          CFG_EXTTB_BIT   = 3;
   localparam int          CFG_ASGA_BIT    = 4;
   localparam int          CFG_ASGB_BIT    = 5;
   localparam int          CFG_ASGT_BIT    = 6;
   localparam int          CFG_EDIT_BIT    = 7;
   // Element config: supervision-only bits at [3:0], single-phase capable at [11:8]
   localparam int          EC_SUPV_LSB     = 0;
   localparam int          EC_ONEP_LSB     = 8;
   localparam logic [31:0] CFG_RST         = 32'h0000_0001;
   localparam logic [31:0] ELEMCFG_RST     = 32'h0000_0000;
   localparam logic [15:0] DELAY_RST       = 16'h0000_0064;
   // Arbitrary identification value
   localparam logic [31:0] IDENT_VALUE     = 32'h5A5A_0001;
   localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;
   typedef enum logic [2:0] {
      PTA_IDLE = 3'b001,
      PTA_RESP = 3'b010,
      PTA_DONE = 3'b100
   } pta_bus_e;
endpackage

/* hdl/pta_element.sv */
// One protective element: alarm on fault, trip after its delay
module pta_element
   import pta_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               rstn,
   input  wire logic               enable,
   input  wire logic               fault,
   input  wire logic [DELAY_W-1:0] delayCycles,
   output logic                    alarm,
   output logic                    trip
);
   logic [DELAY_W-1:0] count_reg;

   // Timer restarts whenever the fault vanishes or the element is held off
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= '0;
         alarm     <= 1'b0;
         trip      <= 1'b0;
      end else if (!enable || !fault) begin
         count_reg <= '0;
         alarm     <= 1'b0;
         trip      <= 1'b0;
      end else begin
         alarm <= 1'b1;
         if (count_reg >= delayCycles) begin
            trip <= 1'b1;
         end else begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end
endmodule

/* bench/pta_top_monitor.sv */
// Port-level assertions for the protection trip aggregator
module pta_top_monitor
   import pta_pkg::*;
(
   input wire logic                 ref_clk,
   input wire logic                 rstn,
   input wire logic                 measValid,
   input wire logic                 nonSetParamEdit,
   input wire logic                 protAvailable,
   input wire logic                 protActive,
   input wire logic                 protection_blocked,
   input wire logic                 generalAlarm,
   input wire logic                 generalTrip,
   input wire logic [NUM_PHASE-1:0] phase_one_trip,
   input wire logic [NUM_ELEM-1:0]  trip_command,
   input wire logic [NUM_ELEM-1:0]  elemAlarmState,
   input wire logic [NUM_ELEM-1:0]  elemTripState
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   property p_resetClear;
      $rose(rstn) |-> !generalAlarm && !generalTrip && trip_command == '0 && !protActive;
   endproperty
   a_resetClear: assert property (p_resetClear) else $error("outputs set after reset");
   // Eight cycles cover the pin synchroniser and agreement stage
   property p_availGate;
      (nonSetParamEdit || !measValid) [*8] |-> !protAvailable;
   endproperty
   a_availGate: assert property (p_availGate) else $error("available while not ready");
   property p_offQuiet;
      (!protActive || protection_blocked) [*8] |-> trip_command == '0 && !generalTrip;
   endproperty
   a_offQuiet: assert property (p_offQuiet) else $error("trip while off or blocked");
   property p_cmdNeedsTrip;
      trip_command != '0 |-> (trip_command & ~(elemTripState | $past(elemTripState))) == '0;
   endproperty
   a_cmdNeedsTrip: assert property (p_cmdNeedsTrip) else $error("command without trip");
   property p_alarmOr;
      generalAlarm |-> (elemAlarmState | $past(elemAlarmState)) != '0;
   endproperty
   a_alarmOr: assert property (p_alarmOr) else $error("general alarm without source");
   property p_tripOr;
      generalTrip |-> (elemTripState | $past(elemTripState)) != '0;
   endproperty
   a_tripOr: assert property (p_tripOr) else $error("general trip without source");
   property p_phaseTrip;
      phase_one_trip != '0 |-> generalTrip || $past(generalTrip);
   endproperty
   a_phaseTrip: assert property (p_phaseTrip) else $error("phase trip alone");
   property p_tripAfterAlarm;
      elemTripState != '0 |-> (elemTripState & ~(elemAlarmState | $past(elemAlarmState))) == '0;
   endproperty
   a_tripAfterAlarm: assert property (p_tripAfterAlarm) else $error("trip without alarm");
endmodule
bind pta_top pta_top_monitor pta_top_monitor_i (.ref_clk(ref_clk), .rstn(rstn),
   .measValid(measValid), .nonSetParamEdit(nonSetParamEdit), .protAvailable(protAvailable),
   .protActive(protActive), .protection_blocked(protection_blocked),
   .generalAlarm(generalAlarm), .generalTrip(generalTrip), .phase_one_trip(phase_one_trip),
   .trip_command(trip_command), .elemAlarmState(elemAlarmState),
   .elemTripState(elemTripState));

/* bench/pta_field_model.sv */
// Protective element field side: fault levels and fault phases
module pta_field_model
   import pta_pkg::*;
(
   input  wire logic                 ref_clk,
   input  wire logic [NUM_ELEM-1:0]  faultReq,
   input  wire logic [NUM_PHASE-1:0] phaseReq,
   output logic      [NUM_ELEM-1:0]  elemFault,
   output logic      [NUM_PHASE-1:0] elemFaultPhase [NUM_ELEM]
);
   logic [NUM_PHASE-1:0] pat = '0;
   always @(posedge ref_clk) begin
      pat <= pat + 3'h1;
      elemFault <= faultReq;
      for (int e = 0; e < NUM_ELEM; e++) begin
         // Idle elements show a moving pattern so stale phases cannot leak
         elemFaultPhase[e] <= faultReq[e] ? phaseReq : pat;
      end
   end
endmodule

/* bench/tb_pta_top.sv */
// Self-checking bench for the protection trip aggregator
module tb_pta_top
   import pta_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] DLY = 16'h0010;
   logic                 ref_clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic                 measValid = 1'b1, nonSetParamEdit = 1'b0, trip_block_input = 1'b0;
   logic                 block_input_a = 1'b0, block_input_b = 1'b0, avs_waitrequest;
   logic                 protAvailable, protActive, protection_blocked, generalAlarm, generalTrip;
   logic [5:0]           avs_address = '0;
   logic [31:0]          avs_writedata = '0, avs_readdata, rdData;
   logic [3:0]           avs_byteenable = 4'hF;
   logic [NUM_ELEM-1:0]  faultReq = '0, elemFault, trip_command, elemAlarmState, elemTripState;
   logic [NUM_PHASE-1:0] phaseReq = '0, phase_one_alarm, phase_one_trip;
   logic [NUM_PHASE-1:0] elemFaultPhase [NUM_ELEM];
   logic [11:0]          obs;
   int                   error_cnt = 0, n_tests = 0, tDly;
   assign obs = {generalAlarm, generalTrip, phase_one_alarm, phase_one_trip, trip_command};
   always #10 ref_clk = ~ref_clk;
   pta_field_model pta_field_model_i (.ref_clk(ref_clk), .faultReq(faultReq),
      .phaseReq(phaseReq), .elemFault(elemFault), .elemFaultPhase(elemFaultPhase));
   pta_top pta_top_i (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .measValid(measValid),
      .nonSetParamEdit(nonSetParamEdit), .block_input_a(block_input_a),
      .block_input_b(block_input_b), .trip_block_input(trip_block_input),
      .elemFault(elemFault), .elemFaultPhase(elemFaultPhase), .protAvailable(protAvailable),
      .protActive(protActive), .protection_blocked(protection_blocked),
      .generalAlarm(generalAlarm), .generalTrip(generalTrip),
      .phase_one_alarm(phase_one_alarm), .phase_one_trip(phase_one_trip),
      .trip_command(trip_command), .elemAlarmState(elemAlarmState),
      .elemTripState(elemTripState));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Request held until waitrequest is sampled low, then released
   task automatic busOp(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge ref_clk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 50);
      if (avs_waitrequest !== 1'b0) chk("waitrequest", 32'h0000_0000, 32'(avs_waitrequest));
      rdData = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic faultRun(input logic [31:0] cfg, input logic [31:0] ecfg, input int e,
                           input logic [2:0] ph, input logic [19:0] exp);
      int i;
      busOp(1'b1, CFG_OFS[7:2], cfg);
      busOp(1'b1, ELEMCFG_OFS[7:2], ecfg);
      repeat (8) @(posedge ref_clk);
      faultReq[e] <= 1'b1;
      phaseReq <= ph;
      for (i = 0; i < 20 && elemAlarmState[e] !== 1'b1; i++) @(posedge ref_clk);
      for (tDly = 0; tDly < DLY + 12 && elemTripState[e] !== 1'b1; tDly++) @(posedge ref_clk);
      repeat (6) @(posedge ref_clk);
      chk("states", exp, {elemAlarmState, elemTripState, obs});
      faultReq <= '0;
      repeat (16) @(posedge ref_clk);
   endtask
   task automatic s_regs();
      busOp(1'b0, CFG_OFS[7:2], '0);
      chk("CFG", CFG_RST, rdData);
      busOp(1'b0, ELEMCFG_OFS[7:2], '0);
      chk("ELEMCFG", ELEMCFG_RST, rdData);
      busOp(1'b0, DELAY0_OFS[7:2] + 6'h3, '0);
      chk("DELAY3", DELAY_RST, rdData[15:0]);
      busOp(1'b0, IDENT_OFS[7:2], '0);
      chk("IDENT", IDENT_VALUE, rdData);
      busOp(1'b1, 6'h09, 32'hFFFF_FFFF);
      busOp(1'b0, 6'h09, '0);
      chk("unmapped", UNMAPPED_DATA, rdData);
      for (int e = 0; e < NUM_ELEM; e++) busOp(1'b1, DELAY0_OFS[7:2] + 6'(e), 32'(DLY));
      busOp(1'b0, DELAY0_OFS[7:2] + 6'h2, '0);
      chk("DELAY2", DLY, rdData[15:0]);
   endtask
   task automatic s_avail();
      measValid <= 1'b0;
      repeat (10) @(posedge ref_clk);
      chk("availMeas", 1'b0, protAvailable);
      measValid <= 1'b1;
      nonSetParamEdit <= 1'b1;
      repeat (10) @(posedge ref_clk);
      chk("availEdit", 1'b0, protAvailable);
      nonSetParamEdit <= 1'b0;
      repeat (10) @(posedge ref_clk);
      chk("availOk", 1'b1, protAvailable);
      chk("active", 1'b1, protActive);
      busOp(1'b1, CFG_OFS[7:2], 32'h0000_0081);
      repeat (2) @(posedge ref_clk);
      chk("availSwEdit", 1'b0, protAvailable);
      busOp(1'b1, CFG_OFS[7:2], 32'h0000_0001);
   endtask
   task automatic s_plain();
      faultRun(32'h0000_0001, 32'h0000_0F00, 0, 3'h1, 20'h1_1C91);
      chk("tripDelay", 1'b1, tDly >= DLY - 1 && tDly <= DLY + 1);
   endtask
   task automatic s_elemCfg();
      faultRun(32'h0000_0001, 32'h0000_0F02, 1, 3'h2, 20'h2_2000);
      faultRun(32'h0000_0001, 32'h0000_0100, 2, 3'h2, 20'h4_4C04);
   endtask
   task automatic s_tripBlk();
      faultRun(32'h0000_0005, 32'h0000_0F00, 0, 3'h1, 20'h1_1C90);
      trip_block_input <= 1'b1;
      faultRun(32'h0000_0049, 32'h0000_0F00, 3, 3'h4, 20'h8_8E40);
      trip_block_input <= 1'b0;
      faultRun(32'h0000_0049, 32'h0000_0F00, 3, 3'h4, 20'h8_8E48);
   endtask
   task automatic s_protBlk();
      block_input_b <= 1'b1;
      faultRun(32'h0000_0033, 32'h0000_0F00, 0, 3'h1, 20'h0_0000);
      chk("blockedB", 1'b1, protection_blocked);
      block_input_b <= 1'b0;
      block_input_a <= 1'b1;
      // Permit set but input A left unassigned: must not block
      faultRun(32'h0000_0003, 32'h0000_0F00, 0, 3'h1, 20'h1_1C91);
      chk("blockedA", 1'b0, protection_blocked);
      block_input_a <= 1'b0;
      faultRun(32'h0000_0000, 32'h0000_0F00, 0, 3'h1, 20'h0_0000);
      chk("inactive", 1'b0, protActive);
   endtask
   // Mid-run reset while an element trips
   task automatic s_reset();
      busOp(1'b1, CFG_OFS[7:2], 32'h0000_0001);
      faultReq <= 4'h1;
      phaseReq <= 3'h1;
      repeat (DLY + 12) @(posedge ref_clk);
      busOp(1'b0, STATUS_OFS[7:2], '0);
      chk("STATUS", 32'h0000_121B, rdData);
      busOp(1'b0, ELEMSTAT_OFS[7:2], '0);
      chk("ELEMSTAT", 32'h0001_0101, rdData);
      rstn <= 1'b0;
      faultReq <= '0;
      repeat (2) @(posedge ref_clk);
      chk("resetOut", 20'h0_0000, {elemAlarmState, elemTripState, obs});
      chk("resetAct", 1'b0, protActive);
      rstn <= 1'b1;
      busOp(1'b0, DELAY0_OFS[7:2], '0);
      chk("DELAY0rst", DELAY_RST, rdData[15:0]);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end
      else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #400_000;
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      s_regs();
      s_avail();
      s_plain();
      s_elemCfg();
      s_tripBlk();
      s_protBlk();
      s_reset();
      summarize();
   end
endmodule
